// ---- core/dpsc_pkg.sv ----
// Constants and types for the digipot serial command block
package dpsc_pkg;
    localparam int          WIPER_W       = 10;       // Wiper code width
    localparam int          TAPS          = 1024;     // Wiper tap count
    localparam int          FUSE_N        = 20;       // Fuse memory locations
    localparam int          FRAME_W       = 16;       // Bits per frame
    localparam logic [4:0]  FULL_BITS     = 5'h10;    // Bits needed to execute
    localparam logic [3:0]  CMD_NOP       = 4'h0;     // No operation
    localparam logic [3:0]  CMD_WR_WIPER  = 4'h1;     // Write wiper
    localparam logic [3:0]  CMD_RD_WIPER  = 4'h2;     // Prepare wiper read
    localparam logic [3:0]  CMD_STORE     = 4'h3;     // Store wiper to fuse
    localparam logic [3:0]  CMD_SW_RST    = 4'h4;     // Software reset
    localparam logic [3:0]  CMD_RD_FUSE   = 4'h5;     // Prepare fuse read
    localparam logic [3:0]  CMD_WR_CTRL   = 4'h6;     // Write control bits
    localparam logic [3:0]  CMD_RD_CTRL   = 4'h7;     // Prepare control read
    localparam logic [3:0]  CMD_SHUTDOWN  = 4'h8;     // Shutdown on/off
    localparam logic [9:0]  MIDSCALE      = 10'h200;  // Wiper after reset, no fuse
    localparam logic [4:0]  FUSE_LAST     = 5'h13;    // Highest fuse address
    localparam logic [4:0]  ADDR_THERM_LO = 5'h14;    // First status location
    localparam logic [4:0]  ADDR_THERM_HI = 5'h15;    // Second status location
    localparam logic [4:0]  THERM_SPLIT   = 5'h0A;    // Ones per status word
    localparam logic [15:0] HIZ_WORD      = 16'h8001; // Arms output release
    localparam logic [7:0]  OFS_LINK      = 8'h00;    // Link enable register
    localparam logic [7:0]  OFS_STATUS    = 8'h04;    // Status register
    localparam logic        LINK_EN_RST   = 1'b1;     // Link enable after reset
    localparam logic [1:0]  RESP_OKAY     = 2'b00;    // AXI okay
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;    // AXI slave error

    // Control register bits, C3 down to C0
    typedef struct packed {
        logic prog_ok;       // Fuse store succeeded
        logic cal_normal;    // 1 selects normal mode
        logic wiper_wr_en;   // Allows wiper writes
        logic fuse_prog_en;  // Allows fuse store
    } dpsc_ctrl_type;
    localparam dpsc_ctrl_type CTRL_RST = 4'h0;  // Control defaults

    // One received frame
    typedef struct packed {
        logic [1:0] spare;   // Unused top bits
        logic [3:0] cmd;     // Command code
        logic [9:0] data;    // Data field
    } dpsc_frame_type;

    // Frame tracking states
    typedef enum {LINK_IDLE, LINK_SHIFT, LINK_EXEC} dpsc_link_state_type;
endpackage

// ---- core/dpsc_tap_decode.sv ----
// One-hot wiper tap decoder
`timescale 1ns/1ps
module dpsc_tap_decode
    import dpsc_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    // Wiper state
    input  wire logic [dpsc_pkg::WIPER_W-1:0] code,
    input  wire logic                        shut,
    // Tap selects
    output logic      [dpsc_pkg::TAPS-1:0]    tap_sel
);
    // One flop per tap; shutdown parks the wiper on the B end
    for (genvar i = 0; i < TAPS; i++)
    begin : g_tap
        wire hit = shut ? (i == 0) : (code == 10'(i));  // Tap match
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                tap_sel[i] <= (i == int'(MIDSCALE));
            else
                tap_sel[i] <= hit;
        end
    end

    tap_onehot_a: assert property (@(posedge clk) disable iff (!arst_n) $onehot(tap_sel))
        else $error("tap select not one-hot");
endmodule

// ---- core/dpsc_top.sv ----
// Serial command control of a single-channel digital potentiometer
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Shutdown command with bit zero set enters shutdown
// - Shutdown leaves wiper register untouched
// - All commands still run during shutdown
// - Shutdown command with bit zero clear exits
// - Fuse addresses 0x00-0x13 return programmed values
// - Addresses 0x14, 0x15 return thermometer counts
// - Prepared read shifts out next frame
// - Command zero, data zero changes nothing except after 0x8001, where it releases output
// - Reset pin rising edge reloads last fuse
// - Software reset reloads like reset pin
// - No fuse programmed: reload midscale
// - Any reset restores control defaults
// - Commands 2, 5, 7 read wiper, fuse, control
// - Output changes on serial clock rise
// - 0x8001 then command zero releases output
// - Daisy chain passes first bits through
// - Calibration bit picks resistor performance mode
// - Wiper code selects exactly one tap
// - Fuse read address is data bits 4:0
// - Calibration bit zero means performance mode
module dpsc_top
    import dpsc_pkg::*;
(
    // Clock and reset
    input  wire logic                         CLK,
    input  wire logic                         ARST_N,
    // Serial link pins
    input  wire logic                         SCLK,
    input  wire logic                         SYNC_N,
    input  wire logic                         DIN,
    input  wire logic                         RESET_PIN,
    output logic                              DOUT_O,
    output logic                              DOUT_OE,
    // Resistor controls
    output logic      [dpsc_pkg::WIPER_W-1:0] WIPER,
    output logic                              SHUTDOWN,
    output logic                              CAL_PERF_MODE,
    output logic      [dpsc_pkg::TAPS-1:0]    TAP_SEL,
    // AXI4-Lite write address
    input  wire logic [7:0]                   S_AXI_AWADDR,
    input  wire logic                         S_AXI_AWVALID,
    output logic                              S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]                  S_AXI_WDATA,
    input  wire logic [3:0]                   S_AXI_WSTRB,
    input  wire logic                         S_AXI_WVALID,
    output logic                              S_AXI_WREADY,
    // AXI4-Lite write response
    output logic      [1:0]                   S_AXI_BRESP,
    output logic                              S_AXI_BVALID,
    input  wire logic                         S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]                   S_AXI_ARADDR,
    input  wire logic                         S_AXI_ARVALID,
    output logic                              S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic      [31:0]                  S_AXI_RDATA,
    output logic      [1:0]                   S_AXI_RRESP,
    output logic                              S_AXI_RVALID,
    input  wire logic                         S_AXI_RREADY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    logic [3:0]          pin_s1;      // First sync stage
    logic [3:0]          pin_s2;      // Second sync stage
    logic                sclk_d;      // Delayed synced clock
    logic                rstp_d;      // Delayed synced reset pin
    dpsc_link_state_type state;       // Frame state
    dpsc_link_state_type next_state;  // Next frame state
    logic [15:0]         shreg;       // Shift register
    logic [4:0]          bit_cnt;     // Bits in frame, saturating
    logic [15:0]         prev_word;   // Last executed frame
    logic [9:0]          wiper;       // Wiper position register
    dpsc_ctrl_type       ctrl;        // Control register
    logic                shut;        // Shutdown flag
    logic                hiz;         // Output released
    logic                dout_oe;     // Registered pull-down enable
    logic [9:0]          fuse_mem [FUSE_N];  // Fuse memory
    logic [4:0]          fuse_cnt;    // Locations programmed
    logic                link_en;     // Software link enable
    logic [9:0]          next_wiper;  // Next wiper
    dpsc_ctrl_type       next_ctrl;   // Next control
    logic                next_shut;   // Next shutdown flag
    logic                next_hiz;    // Next release flag

    // Synchronise pins: clock, select, data, reset
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
            sclk_d <= 1'b1;
            rstp_d <= 1'b1;
        end
        else
        begin
            pin_s1 <= {SCLK, SYNC_N, DIN, RESET_PIN};
            pin_s2 <= pin_s1;
            sclk_d <= pin_s2[3];
            rstp_d <= pin_s2[0];
        end
    end

    // Decoded pin events
    wire sclk_rise   = pin_s2[3] & ~sclk_d;       // Serial clock edge
    wire sync_n_s    = pin_s2[2];                 // Frame select level
    wire din_s       = pin_s2[1];                 // Data bit
    wire hw_rst_rise = pin_s2[0] & ~rstp_d;       // Reset pin edge
    wire exec        = (state == LINK_EXEC);      // Frame executes
    wire shifting    = (state == LINK_SHIFT) & sclk_rise;

    // Frame fields
    dpsc_frame_type frame;
    assign frame = shreg;
    wire [3:0] cmd      = frame.cmd;
    wire [4:0] rd_addr  = frame.data[4:0];
    wire       is_rd    = (cmd == CMD_RD_WIPER) | (cmd == CMD_RD_FUSE) | (cmd == CMD_RD_CTRL);

    // Frame state: shift while select is low, execute on its rise if 16 bits came in and the link is enabled
    always_comb
    begin
        next_state = state;
        case (state)
            LINK_IDLE:
                if (!sync_n_s)
                    next_state = LINK_SHIFT;
            LINK_SHIFT:
                if (sync_n_s)
                    next_state = (bit_cnt == FULL_BITS && link_en) ? LINK_EXEC : LINK_IDLE;
            LINK_EXEC:
                next_state = LINK_IDLE;
            default:
                next_state = LINK_IDLE;
        endcase
    end

    // State and bit counter
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state   <= LINK_IDLE;
            bit_cnt <= 5'h0;
        end
        else
        begin
            state <= next_state;
            if (state == LINK_IDLE)
                bit_cnt <= 5'h0;
            else if (shifting && bit_cnt != FULL_BITS)
                bit_cnt <= bit_cnt + 5'h1;
        end
    end

    // Fuse status as thermometer words
    function automatic logic [9:0] therm(input logic [4:0] n);
        logic [9:0] t;
        t = ~(10'h3FF << n);
        return t;
    endfunction
    wire [4:0] cnt_lo = (fuse_cnt >= THERM_SPLIT) ? THERM_SPLIT : fuse_cnt;
    wire [4:0] cnt_hi = (fuse_cnt > THERM_SPLIT) ? 5'(fuse_cnt - THERM_SPLIT) : 5'h0;

    // Readback word selection
    wire [9:0] fuse_word = (rd_addr <= FUSE_LAST) ? fuse_mem[rd_addr] :
                           (rd_addr == ADDR_THERM_LO) ? therm(cnt_lo) :
                           (rd_addr == ADDR_THERM_HI) ? therm(cnt_hi) : 10'h000;
    wire [9:0] rb_word   = (cmd == CMD_RD_WIPER) ? wiper :
                           (cmd == CMD_RD_FUSE) ? fuse_word : {6'h00, ctrl};

    // Shift in MSB first; the word pushed out feeds the next device
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            shreg <= 16'h0000;
        else if (shifting)
            shreg <= {shreg[14:0], din_s};
        else if (exec && is_rd)
            shreg <= {6'h00, rb_word};
    end

    // Reload source: last programmed location or midscale
    wire [9:0] reload   = (fuse_cnt == 5'h0) ? MIDSCALE : fuse_mem[5'(fuse_cnt - 5'h1)];
    wire       store_go = exec & (cmd == CMD_STORE) & ctrl.fuse_prog_en & (fuse_cnt <= FUSE_LAST);
    wire       any_rst  = hw_rst_rise | (exec & (cmd == CMD_SW_RST));

    // Command execution; shutdown works alongside every command
    always_comb
    begin
        next_wiper = wiper;
        next_ctrl  = ctrl;
        next_shut  = shut;
        next_hiz   = hiz;
        if (any_rst)
        begin
            next_wiper = reload;
            next_ctrl  = CTRL_RST;
        end
        if (exec)
        begin
            // Nonzero command takes output out of release
            next_hiz = (cmd == CMD_NOP) ? (hiz | (prev_word == HIZ_WORD)) : 1'b0;
            case (cmd)
                CMD_WR_WIPER:
                    if (ctrl.wiper_wr_en)
                        next_wiper = frame.data;
                CMD_STORE:
                    if (store_go)
                        next_ctrl.prog_ok = 1'b1;
                CMD_WR_CTRL:
                    next_ctrl = {ctrl.prog_ok, frame.data[2:0]};
                CMD_SHUTDOWN:
                    next_shut = frame.data[0];
                default:
                    next_shut = shut;
            endcase
        end
    end

    // Wiper, control and flags
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wiper     <= MIDSCALE;
            ctrl      <= CTRL_RST;
            shut      <= 1'b0;
            hiz       <= 1'b0;
            prev_word <= 16'h0000;
        end
        else
        begin
            wiper <= next_wiper;
            ctrl  <= next_ctrl;
            shut  <= next_shut;
            hiz   <= next_hiz;
            if (exec)
                prev_word <= shreg;
        end
    end

    // Fuse memory, one entry written per store
    for (genvar i = 0; i < FUSE_N; i++)
    begin : g_fuse
        always_ff @(posedge CLK or negedge ARST_N)
        begin
            if (!ARST_N)
                fuse_mem[i] <= 10'h000;
            else if (store_go && fuse_cnt == 5'(i))
                fuse_mem[i] <= wiper;
        end
    end

    // Programmed count
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            fuse_cnt <= 5'h00;
        else if (store_go)
            fuse_cnt <= fuse_cnt + 5'h01;
    end

    // Open drain output: each serial clock rise shows the bit pushed out,
    // so the far side takes it on the falling edge; release wins
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            dout_oe <= 1'b0;
        else if (hiz)
            dout_oe <= 1'b0;
        else if (shifting)
            dout_oe <= ~shreg[15];
    end

    assign DOUT_O        = 1'b0;
    assign DOUT_OE       = dout_oe;
    assign WIPER         = wiper;
    assign SHUTDOWN      = shut;
    assign CAL_PERF_MODE = ~ctrl.cal_normal;

    // Tap decoder
    dpsc_tap_decode u_tap (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .code    (wiper),
        .shut    (shut),
        .tap_sel (TAP_SEL)
    );

    // AXI4-Lite slave: address and data may come in either order
    logic       aw_held;  // Write address taken
    logic       w_held;   // Write data taken
    logic [7:0] aw_addr;  // Held write address
    logic [31:0] w_data;  // Held write data
    logic [3:0] w_strb;   // Held byte enables
    logic       bvalid;   // Response pending
    logic [1:0] bresp;    // Response code
    logic       rvalid;   // Read data pending
    logic [31:0] rdata;   // Read data
    logic [1:0] rresp;    // Read response

    wire aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take   = S_AXI_WVALID & S_AXI_WREADY;
    wire wr_go    = aw_held & w_held & ~bvalid;
    wire wr_link  = (aw_addr == OFS_LINK);
    wire rd_link  = (S_AXI_ARADDR == OFS_LINK);
    wire rd_stat  = (S_AXI_ARADDR == OFS_STATUS);
    wire [31:0] status = {7'h00, fuse_cnt, 2'h0, hiz, shut, 2'h0, ctrl, wiper};

    assign S_AXI_AWREADY = ~aw_held & ~bvalid;
    assign S_AXI_WREADY  = ~w_held & ~bvalid;
    assign S_AXI_ARREADY = ~rvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;

    // Write path
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            link_en <= LINK_EN_RST;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_link ? RESP_OKAY : RESP_SLVERR;
                if (wr_link && w_strb[0])
                    link_en <= w_data[0];
            end
            else if (bvalid && S_AXI_BREADY)
                bvalid <= 1'b0;
        end
    end

    // Read path, answer one cycle after the address
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_link ? {31'h0, link_en} : (rd_stat ? status : 32'h0000_0000);
            rresp  <= (rd_link | rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && S_AXI_RREADY)
            rvalid <= 1'b0;
    end

    // Checks on command behaviour
    shut_on_a: assert property (exec && cmd == CMD_SHUTDOWN && frame.data[0] |=> shut)
        else $error("shutdown not entered");
    shut_keep_a: assert property (exec && cmd == CMD_SHUTDOWN && !hw_rst_rise |=> $stable(wiper))
        else $error("wiper moved on shutdown");
    shut_cmds_a: assert property (shut && exec && cmd == CMD_WR_WIPER && ctrl.wiper_wr_en && !hw_rst_rise
        |=> wiper == $past(shreg[9:0]))
        else $error("wiper write lost in shutdown");
    shut_off_a: assert property (exec && cmd == CMD_SHUTDOWN && !frame.data[0] |=> !shut)
        else $error("shutdown not left");
    fuse_read_a: assert property (exec && cmd == CMD_RD_FUSE && rd_addr <= FUSE_LAST
        |-> rb_word == fuse_mem[rd_addr])
        else $error("fuse readback wrong");
    therm_lo_a: assert property (exec && cmd == CMD_RD_FUSE && rd_addr == ADDR_THERM_LO
        |=> (shreg & 16'(shreg + 16'h1)) == 16'h0000
            && $countones(shreg) == ((fuse_cnt >= THERM_SPLIT) ? int'(THERM_SPLIT) : int'(fuse_cnt)))
        else $error("status word wrong");
    read_load_a: assert property (exec && is_rd |=> shreg[15:10] == 6'h00 && shreg[9:0] == $past(rb_word))
        else $error("readback not loaded");
    nop_keep_a: assert property (exec && shreg == 16'h0000 && !hw_rst_rise
        |=> $stable(wiper) && $stable(ctrl) && $stable(shut))
        else $error("no-op changed state");
    hw_mid_a: assert property (hw_rst_rise && fuse_cnt == 5'h0 && !exec |=> wiper == MIDSCALE && ctrl == CTRL_RST)
        else $error("reset reload wrong");
    sw_reload_a: assert property (exec && cmd == CMD_SW_RST && fuse_cnt != 5'h0
        |=> wiper == fuse_mem[5'(fuse_cnt - 5'h1)] && ctrl == CTRL_RST)
        else $error("software reset reload wrong");
    dout_edge_a: assert property ($changed(dout_oe) |-> $past(shifting) || $past(exec, 2))
        else $error("output moved off clock edge");
    dout_bit_a: assert property (shifting && !hiz |=> dout_oe == !$past(shreg[15]))
        else $error("output bit wrong");
    hiz_set_a: assert property (exec && cmd == CMD_NOP && prev_word == HIZ_WORD |=> hiz ##1 !DOUT_OE)
        else $error("output not released");
    cal_mode_a: assert property (exec && cmd == CMD_WR_CTRL && !hw_rst_rise
        |=> CAL_PERF_MODE == !$past(shreg[2]))
        else $error("calibration mode wrong");
    exec_full_a: assert property (exec |-> $past(bit_cnt) == FULL_BITS)
        else $error("short frame executed");
    shut_rst_a: assert property (any_rst && !exec |=> $stable(shut))
        else $error("reset altered shutdown");

    shut_c: cover property (exec && cmd == CMD_SHUTDOWN && frame.data[0]);
    read_c: cover property (exec && cmd == CMD_RD_FUSE);
    hiz_c: cover property ($rose(hiz));
    hwrst_c: cover property (hw_rst_rise);
endmodule

// ---- tb/dpsc_host.sv ----
// Serial host model: frames commands and samples the output line
`timescale 1ns/1ps
module dpsc_host
(
    // Clock and serial pins
    input  wire logic clk,
    output logic      sclk = 1'b0,
    output logic      sync_n = 1'b1,
    output logic      din = 1'b0,
    input  wire logic line
);
    // Shift n bits MSB first, sampling the line before each fall
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = '0;
        @(posedge clk);
        sync_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din <= w[i];
            repeat (3) @(posedge clk);
            sclk <= 1'b1;
            repeat (5) @(posedge clk);
            r = {r[30:0], line};
            sclk <= 1'b0;
        end
        repeat (3) @(posedge clk);
        sync_n <= 1'b1;
        din <= ~din;
        repeat (10) @(posedge clk);
    endtask
endmodule

// ---- tb/test_dpsc_top.sv ----
// Self-checking bench for the digipot serial command block
`timescale 1ns/1ps
module test_dpsc_top;
    import dpsc_pkg::*;
    // Pins, bus channels, results and counters
    logic            clk = 1'b0, arst_n = 1'b0, rst_pin = 1'b0;
    logic            sclk, sync_n, din, dout_o, dout_oe, shut, cal, awready, wready, bvalid, arready, rvalid;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]      awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]     wdata = 32'h0, rdata, rx, rd;
    logic [1:0]      bresp, rresp, resp;
    logic [9:0]      wiper;
    logic [TAPS-1:0] taps;
    int              err_total = 0, n_compared = 0;
    always #5 clk = ~clk;
    dpsc_top dpsc_top_i (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .SYNC_N(sync_n), .DIN(din), .RESET_PIN(rst_pin),
        .DOUT_O(dout_o), .DOUT_OE(dout_oe), .WIPER(wiper), .SHUTDOWN(shut), .CAL_PERF_MODE(cal), .TAP_SEL(taps),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    // Host; the output line is pulled up when released
    dpsc_host dpsc_host_i (.clk(clk), .sclk(sclk), .sync_n(sync_n), .din(din), .line(dout_oe ? dout_o : 1'b1));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Exactly one tap selected
    task automatic chkt(input logic [9:0] i);
        logic [TAPS-1:0] e;
        e = '0;
        e[i] = 1'b1;
        chk({31'h0, taps === e}, 32'h1);
    endtask
    task automatic f(input logic [15:0] w);
        dpsc_host_i.xfer({16'h0, w}, 16, rx);
    endtask
    // Bus write: both channels offered, each released once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // Bus read
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial
    begin
        #400us;
        err_total++;
        end_sim();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        chk({shut, cal, wiper}, 12'h600);
        chkt(MIDSCALE);
        axr(8'h08);
        chk(resp, RESP_SLVERR);
        axw(OFS_STATUS, 32'h0);
        chk(resp, RESP_SLVERR);
        f(16'h1803);
        f(16'h0555);
        chkt(10'h155);
        rst_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk({cal, wiper}, 11'h600);
        rst_pin <= 1'b0;
        f(16'h1803);
        f(16'h0555);
        f(16'h2001);
        chk({shut, wiper}, 11'h555);
        chkt(10'h000);
        f(16'h0466);
        f(16'h2000);
        chk({shut, wiper}, 11'h066);
        f(16'h0800);
        f(16'h0000);
        chk(rx, 32'h0066);
        f(16'h0C00);
        f(16'h1414);
        f(16'h1415);
        chk(rx, 32'h0001);
        f(16'h1400);
        f(16'h0000);
        chk(rx, 32'h0066);
        f(16'h1807);
        chk(cal, 1'b0);
        f(16'h2001);
        f(16'h1000);
        chk({shut, cal, wiper}, 12'hC66);
        f(16'h2000);
        f(16'h1803);
        f(16'h0511);
        axr(OFS_STATUS);
        chk(rd[16:0], 17'h00D11);
        rst_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk({cal, wiper}, 11'h466);
        axw(OFS_LINK, 32'h0);
        f(16'h2001);
        chk(shut, 1'b0);
        axw(OFS_LINK, 32'h1);
        f(16'h8001);
        f(16'h0000);
        f(16'h1C00);
        chk(rx, 32'hFFFF);
        dpsc_host_i.xfer(32'h18030000, 32, rx);
        chk(rx, 32'h1803);
        end_sim();
    end
endmodule
